// ==== hdl/tlia_top.v ====
// How it works
// - Each source has one level-select bit
// - All level-select bits reset to low
// - High preempts low; high never preempted
// - Preempted low routine resumes after high returns
// - High level wins, then fixed source ranking
// - Ranks 0..18, vectors 0x0003 step eight
// - Requests sampled and decoded every cycle
// - Fastest response seven cycles, five-cycle call
// - One instruction after return before next call
// - Worst case nineteen cycles including divide
// - Equal or lower level waits for return
// - Line A: vector 0x0003, rank 0, auto-clear
// - Line B: vector 0x0013, rank 2, auto-clear
// - Read-only warn flags gated by enable only
// - Global enable clear blocks, requests stay pending
// - Flag still set after return re-requests
// - Software-set flag requests like hardware one
//
// Local design decisions: strobed register access and the placing of the registers.
`include "tlia_map.vh"
`timescale 1ns/1ps
`default_nettype none

module tlia_top #(
	parameter NSRC = 19
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire nrst_i,
	// Register port
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// Peripheral event pulses, same clock
	input wire [NSRC-1:0] src_evt_i,
	// Pins from outside the clock domain
	input wire ext_request_line_a_i,
	input wire ext_request_line_b_i,
	input wire core_supply_warn_flag_i,
	input wire battery_supply_warn_flag_i,
	input wire port_match_i,
	// CPU sequencer
	input wire cpu_instr_done_i,
	input wire cpu_return_from_isr_op_i,
	output reg call_req_o,
	output reg [15:0] call_vector_o,
	output reg call_busy_o,
	// Interrupt line
	output reg irq_o
);

	//--------------------------------------------------
	// Storage
	//--------------------------------------------------
	reg gie_ff; // Global enable
	reg [NSRC-1:0] en_ff; // Per-source enables
	reg [NSRC-1:0] pri_ff; // Per-source level bits
	reg [NSRC-1:0] pnd_ff; // Writable pending flags
	reg [NSRC-1:0] req_ff; // Sampled requests
	reg hi_act_ff; // High routine in service
	reg lo_act_ff; // Low routine in service
	reg [2:0] call_cnt_ff; // Call sequence countdown
	reg wait_instr_ff; // Post-return status flag, cleared at next boundary
	reg [1:0] istat_ff; // Sticky events
	reg [1:0] imask_ff; // Event mask
	// Pin synchronisers, first stage read only by second
	reg [4:0] sync1_ff;
	reg [4:0] sync2_ff;
	reg [1:0] ext_old_ff; // Previous line levels
	wire [NSRC-1:0] pnd_all; // Flags including read-only ones
	wire [1:0] ext_fall; // Falling edge on lines A and B
	wire [NSRC-1:0] elig; // Enabled and pending
	wire [NSRC-1:0] hw_set; // Hardware set per source
	reg [4:0] win_idx; // Winning rank
	reg win_hi; // Winner level
	reg win_vld; // Some request may be taken
	reg [7:0] nxt_rdata;
	wire take; // Call issued this cycle
	wire wr_pnd0;
	wire wr_pnd1;
	wire wr_pnd2;
	wire [1:0] ist_evt; // Call and preemption events
	wire [1:0] ist_clr; // Write-one clear bits
	localparam [NSRC-1:0] HW_CLR = `TLIA_HW_CLR_MASK; // Cleared on vectoring
	//--------------------------------------------------
	// Pin synchronisation
	//--------------------------------------------------
	// Two flops before any logic looks at the pins
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			sync1_ff <= 5'h0F; // Idle: lines and warnings high
			sync2_ff <= 5'h0F;
			ext_old_ff <= 2'h3;
		end else begin
			sync1_ff <= {port_match_i,
				battery_supply_warn_flag_i,
				core_supply_warn_flag_i,
				ext_request_line_b_i, ext_request_line_a_i};
			sync2_ff <= sync1_ff;
			ext_old_ff <= sync2_ff[1:0];
		end
	end

	// Lines are active low, falling edge latches the flag
	assign ext_fall = ext_old_ff & ~sync2_ff[1:0];

	//--------------------------------------------------
	// Pending flags
	//--------------------------------------------------
	assign wr_pnd0 = reg_wr_i && (reg_addr_i == `TLIA_ADDR_PND0);
	assign wr_pnd1 = reg_wr_i && (reg_addr_i == `TLIA_ADDR_PND1);
	assign wr_pnd2 = reg_wr_i && (reg_addr_i == `TLIA_ADDR_PND2);

	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : g_src
			wire sw_wr;
			wire sw_val;
			if (g < 7) begin : g_b0
				assign sw_wr = wr_pnd0;
				assign sw_val = reg_wdata_i[g];
			end else if (g < 15) begin : g_b1
				assign sw_wr = wr_pnd1;
				assign sw_val = reg_wdata_i[g-7];
			end else begin : g_b2
				assign sw_wr = wr_pnd2;
				assign sw_val = reg_wdata_i[g-15];
			end
			// Line A and B hardware set comes only from their pins
			if (g == `TLIA_SRC_EXT_A) begin : g_ea
				assign hw_set[g] = ext_fall[0];
			end else if (g == `TLIA_SRC_EXT_B) begin : g_eb
				assign hw_set[g] = ext_fall[1];
			end else begin : g_pe
				assign hw_set[g] = src_evt_i[g];
			end
			// Hardware set beats any clear in the same cycle
			always @(posedge sys_clk_i) begin
				if (!nrst_i) begin
					pnd_ff[g] <= 1'b0;
				end else if (hw_set[g]) begin
					pnd_ff[g] <= 1'b1;
				end else if (sw_wr) begin
					pnd_ff[g] <= sw_val;
				end else if (take && (win_idx == g) && HW_CLR[g]) begin
					pnd_ff[g] <= 1'b0;
				end
			end
			// Level-held sources bypass the writable flag
			if (g == `TLIA_SRC_WARN) begin : g_w
				assign pnd_all[g] = ~sync2_ff[2] | ~sync2_ff[3];
			end else if (g == `TLIA_SRC_PMATCH) begin : g_pm
				assign pnd_all[g] = sync2_ff[4];
			end else begin : g_f
				assign pnd_all[g] = pnd_ff[g];
			end
		end
	endgenerate

	// Enables gate only; flags stay put while blocked
	assign elig = {NSRC{gie_ff}} & en_ff & pnd_all;

	//--------------------------------------------------
	// Sampling and decode
	//--------------------------------------------------
	// One registered sample of requests each cycle
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			req_ff <= {NSRC{1'b0}};
		end else begin
			req_ff <= elig;
		end
	end

	// Lowest rank wins within the highest allowed level
	always @* begin : p_decode
		integer i;
		win_idx = 5'h0_0;
		win_hi = 1'b0;
		win_vld = 1'b0;
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (req_ff[i] && !pri_ff[i] && !lo_act_ff && !hi_act_ff) begin
				win_idx = i[4:0];
				win_vld = 1'b1;
			end
		end
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (req_ff[i] && pri_ff[i] && !hi_act_ff) begin
				win_idx = i[4:0];
				win_hi = 1'b1;
				win_vld = 1'b1;
			end
		end
	end

	// Boundary after a return closes its one extra instruction
	assign take = win_vld && cpu_instr_done_i && !cpu_return_from_isr_op_i &&
		(call_cnt_ff == 3'h0);

	//--------------------------------------------------
	// Service level tracking
	//--------------------------------------------------
	// Two-deep stack: high sits above an optional low
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			hi_act_ff <= 1'b0;
			lo_act_ff <= 1'b0;
			wait_instr_ff <= 1'b0;
		end else begin
			if (take) begin
				if (win_hi) begin
					hi_act_ff <= 1'b1;
				end else begin
					lo_act_ff <= 1'b1;
				end
			end else if (cpu_return_from_isr_op_i) begin
				// Pop the top level, low resumes after high
				if (hi_act_ff) begin
					hi_act_ff <= 1'b0;
				end else begin
					lo_act_ff <= 1'b0;
				end
			end
			// Status only: a return until the next boundary
			if (cpu_return_from_isr_op_i) begin
				wait_instr_ff <= 1'b1;
			end else if (cpu_instr_done_i) begin
				wait_instr_ff <= 1'b0;
			end
		end
	end

	//--------------------------------------------------
	// Call sequence
	//--------------------------------------------------
	// Hold off new calls for the call duration
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			call_cnt_ff <= 3'h0;
			call_req_o <= 1'b0;
			call_vector_o <= 16'h0000;
			call_busy_o <= 1'b0;
		end else begin
			call_req_o <= take;
			if (take) begin
				call_cnt_ff <= `TLIA_CALL_CYC;
				call_vector_o <= `TLIA_VEC_BASE +
					({11'h000, win_idx} << 3);
			end else if (call_cnt_ff != 3'h0) begin
				call_cnt_ff <= call_cnt_ff - 3'h1;
			end
			call_busy_o <= take || (call_cnt_ff > 3'h1);
		end
	end

	//--------------------------------------------------
	// Configuration registers
	//--------------------------------------------------
	// Level bits start low for every source
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			gie_ff <= 1'b0;
			en_ff <= {NSRC{1'b0}};
			pri_ff <= {NSRC{1'b0}};
			imask_ff <= 2'h0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`TLIA_ADDR_EN0: begin
					gie_ff <= reg_wdata_i[`TLIA_GIE_BIT];
					en_ff[6:0] <= reg_wdata_i[6:0];
				end
				`TLIA_ADDR_EN1: en_ff[14:7] <= reg_wdata_i;
				`TLIA_ADDR_EN2: en_ff[18:15] <= reg_wdata_i[3:0];
				`TLIA_ADDR_PRI0: pri_ff[6:0] <= reg_wdata_i[6:0];
				`TLIA_ADDR_PRI1: pri_ff[14:7] <= reg_wdata_i;
				`TLIA_ADDR_PRI2: pri_ff[18:15] <= reg_wdata_i[3:0];
				`TLIA_ADDR_IMASK: imask_ff <= reg_wdata_i[1:0];
				default: begin // Other offsets hold no config
				end
			endcase
		end
	end

	//--------------------------------------------------
	// Event status and interrupt line
	//--------------------------------------------------
	assign ist_evt = {take && win_hi && lo_act_ff, take};
	assign ist_clr = (reg_wr_i && (reg_addr_i == `TLIA_ADDR_ISTAT)) ?
		reg_wdata_i[1:0] : 2'h0;
	// New event beats a write-one clear in the same cycle
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			istat_ff <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			istat_ff <= (istat_ff & ~ist_clr) | ist_evt;
			irq_o <= |(((istat_ff & ~ist_clr) | ist_evt) & imask_ff);
		end
	end

	//--------------------------------------------------
	// Read port
	//--------------------------------------------------
	// Unmapped offsets read as zero
	always @* begin
		nxt_rdata = 8'h00;
		case (reg_addr_i)
			`TLIA_ADDR_EN0: nxt_rdata = {gie_ff, en_ff[6:0]};
			`TLIA_ADDR_EN1: nxt_rdata = en_ff[14:7];
			`TLIA_ADDR_EN2: nxt_rdata = {4'h0, en_ff[18:15]};
			`TLIA_ADDR_PRI0: nxt_rdata = `TLIA_PRI0_RD_ONE |
				{1'b0, pri_ff[6:0]};
			`TLIA_ADDR_PRI1: nxt_rdata = pri_ff[14:7];
			`TLIA_ADDR_PRI2: nxt_rdata = {4'h0, pri_ff[18:15]};
			`TLIA_ADDR_PND0: nxt_rdata = {1'b0, pnd_all[6:0]};
			`TLIA_ADDR_PND1: nxt_rdata = pnd_all[14:7];
			`TLIA_ADDR_PND2: nxt_rdata = {4'h0, pnd_all[18:15]};
			`TLIA_ADDR_ISTAT: nxt_rdata = {6'h00, istat_ff};
			`TLIA_ADDR_IMASK: nxt_rdata = {6'h00, imask_ff};
			`TLIA_ADDR_STATE: nxt_rdata = {hi_act_ff, lo_act_ff,
				wait_instr_ff, win_vld, call_cnt_ff == 3'h0, 3'h0};
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= reg_rd_i ? nxt_rdata : 8'h00;
		end
	end

endmodule // tlia_top

`default_nettype wire

// ==== hdl/tlia_map.vh ====
`ifndef TLIA_MAP_VH
`define TLIA_MAP_VH

// Register offsets on the plain register port
`define TLIA_ADDR_EN0 4'h0
`define TLIA_ADDR_EN1 4'h1
`define TLIA_ADDR_EN2 4'h2
`define TLIA_ADDR_PRI0 4'h3
`define TLIA_ADDR_PRI1 4'h4
`define TLIA_ADDR_PRI2 4'h5
`define TLIA_ADDR_PND0 4'h6
`define TLIA_ADDR_PND1 4'h7
`define TLIA_ADDR_PND2 4'h8
`define TLIA_ADDR_ISTAT 4'h9
`define TLIA_ADDR_IMASK 4'hA
`define TLIA_ADDR_STATE 4'hB

// Field positions
`define TLIA_GIE_BIT 7
`define TLIA_SRC_EXT_A 0
`define TLIA_SRC_EXT_B 2
`define TLIA_SRC_WARN 15
`define TLIA_SRC_PMATCH 16
`define TLIA_EVT_CALL 0
`define TLIA_EVT_PREEMPT 1

// Reset values
`define TLIA_EN_RST 8'h00
`define TLIA_PRI_RST 8'h00
`define TLIA_PRI0_RD_ONE 8'h80

// Sources that lose their pending flag when vectored
`define TLIA_HW_CLR_MASK 19'h0_000F

// Vector layout
`define TLIA_VEC_BASE 16'h0003
`define TLIA_VEC_STEP 16'h0008
`define TLIA_VEC_LAST 16'h0093

// Timing, in system clock cycles
`define TLIA_DETECT_CYC 1
`define TLIA_CALL_CYC 3'h5
`define TLIA_RETURN_FROM_ISR_OP_CYC 5
`define TLIA_DIV_CYC 8
`define TLIA_MIN_RESP_CYC 7
`define TLIA_MAX_RESP_CYC 19

`endif

// ==== dv/tlia_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Call timing checker
// ------------------------------
module tlia_monitor (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Register reads
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// CPU side
	input wire logic cpu_instr_done_i,
	input wire logic cpu_return_from_isr_op_i,
	input wire logic call_req_o,
	input wire logic [15:0] call_vector_o,
	input wire logic call_busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// Call sequence: one start pulse, five busy cycles
	sequence s_busy_run;
		call_busy_o[*5];
	endsequence
	sequence s_no_restart;
		!call_req_o[*4];
	endsequence
	chk_busy_five:
		assert property (call_req_o |-> s_busy_run) else $error("busy short");
	chk_req_single:
		assert property (call_req_o |=> s_no_restart) else $error("call overlap");
	chk_call_on_done:
		assert property (call_req_o |-> $past(cpu_instr_done_i))
		else $error("call off boundary");
	chk_return_from_isr_op_holds:
		assert property (cpu_return_from_isr_op_i |=> !call_req_o) else $error("call at return");
	chk_vec_grid:
		assert property (call_req_o |-> call_vector_o[2:0] == 3'b011
			&& call_vector_o <= 16'h0093) else $error("vector off grid");
	chk_vec_held:
		assert property (!call_req_o |-> $stable(call_vector_o))
		else $error("vector moved");
	chk_busy_cause:
		assert property ($rose(call_busy_o) |-> call_req_o)
		else $error("busy without call");
	// Read data must be quiet outside the answer cycle
	chk_rdata_idle:
		assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("rdata not idle");
endmodule // tlia_monitor
bind tlia_top tlia_monitor i_mon (.sys_clk_i, .nrst_i, .reg_rd_i, .reg_rdata_o,
	.cpu_instr_done_i, .cpu_return_from_isr_op_i, .call_req_o, .call_vector_o, .call_busy_o);
`default_nettype wire

// ==== dv/tlia_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// CPU sequencer stand-in
// ------------------------------
module tlia_cpu_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Controls
	input wire logic call_busy_i,
	input wire logic slow_i,
	input wire logic return_from_isr_op_cmd_i,
	// Boundaries
	output logic instr_done_o,
	output logic return_from_isr_op_o
);
	logic pace_ff; // Halves the pace in slow mode
	// One boundary per cycle, every other cycle when slow; none during a call or a return
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			pace_ff <= 1'b0;
			instr_done_o <= 1'b0;
			return_from_isr_op_o <= 1'b0;
		end else begin
			pace_ff <= ~pace_ff;
			return_from_isr_op_o <= return_from_isr_op_cmd_i;
			instr_done_o <= !call_busy_i && !return_from_isr_op_cmd_i && (!slow_i || pace_ff);
		end
	end
endmodule // tlia_cpu_model
`default_nettype wire

// ==== dv/tb_two_level_irq_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tlia_map.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module tb_two_level_irq_arbiter;
	logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, ext_a, warn_n, return_from_isr_op_cmd, slow;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic done, return_from_isr_op, call_req, busy, irq;
	logic [15:0] vec;
	int err_total, compares;
	tlia_top #(.NSRC(19)) i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_evt_i(19'h0_0000),
		.ext_request_line_a_i(ext_a), .ext_request_line_b_i(1'b1),
		.core_supply_warn_flag_i(warn_n), .battery_supply_warn_flag_i(1'b1),
		.port_match_i(1'b0), .cpu_instr_done_i(done), .cpu_return_from_isr_op_i(return_from_isr_op),
		.call_req_o(call_req), .call_vector_o(vec), .call_busy_o(busy), .irq_o(irq));
	tlia_cpu_model i_cpu (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .call_busy_i(busy),
		.slow_i(slow), .return_from_isr_op_cmd_i(return_from_isr_op_cmd), .instr_done_o(done), .return_from_isr_op_o(return_from_isr_op));
	// 250 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// Bus tasks, one strobe cycle each
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		`CHK("rdata", e, reg_rdata_o)
	endtask
	// Bounded wait for a call, then its vector
	task wait_call(input logic [15:0] e);
		int n;
		n = 0;
		while (call_req !== 1'b1 && n < 80) begin
			@(negedge sys_clk_i);
			n++;
		end
		`CHK("vector", e, vec)
		if (call_req !== 1'b1) begin
			err_total++;
			give_verdict();
		end
		@(negedge sys_clk_i);
	endtask
	// No call may start for n cycles
	task quiet(input int n);
		int seen;
		seen = 0;
		repeat (n) begin
			@(negedge sys_clk_i);
			if (call_req !== 1'b0) seen++;
		end
		`CHK("calls", 0, seen)
	endtask
	task ret;
		@(posedge sys_clk_i);
		return_from_isr_op_cmd <= 1'b1;
		@(posedge sys_clk_i);
		return_from_isr_op_cmd <= 1'b0;
	endtask
	task give_verdict;
		$display("Counts: %0d compares, %0d errors", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		{nrst_i, reg_wr_i, reg_rd_i, return_from_isr_op_cmd, slow} = 5'b0;
		{ext_a, warn_n, reg_addr_i, reg_wdata_i} = {2'b11, 12'h000};
		repeat (10) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		// Reset values, unmapped offset
		rd(`TLIA_ADDR_PRI0, 8'h80);
		rd(`TLIA_ADDR_PRI2, 8'h00);
		rd(4'hF, 8'h00);
		wr(`TLIA_ADDR_PRI1, 8'hFF);
		rd(`TLIA_ADDR_PRI1, 8'hFF);
		$display("reset values done");
		// Held while global enable is off, software-set flags
		wr(`TLIA_ADDR_IMASK, 8'h03);
		wr(`TLIA_ADDR_EN0, 8'h12);
		wr(`TLIA_ADDR_PND0, 8'h12);
		quiet(20);
		rd(`TLIA_ADDR_PND0, 8'h12);
		wr(`TLIA_ADDR_PRI0, 8'h10);
		wr(`TLIA_ADDR_EN0, 8'h92);
		wait_call(16'h0023);
		repeat (2) @(negedge sys_clk_i);
		`CHK("irq", 1'b1, irq)
		$display("level arbitration done");
		// High routine blocks low; unserved flag re-enters
		quiet(20);
		ret();
		wait_call(16'h0023);
		wr(`TLIA_ADDR_PND0, 8'h02);
		ret();
		wait_call(16'h000B);
		rd(`TLIA_ADDR_PND0, 8'h00);
		// High preempts low
		wr(`TLIA_ADDR_PND0, 8'h10);
		wait_call(16'h0023);
		rd(`TLIA_ADDR_ISTAT, 8'h03);
		wr(`TLIA_ADDR_ISTAT, 8'h03);
		wr(`TLIA_ADDR_EN0, 8'h81);
		@(negedge sys_clk_i);
		`CHK("irq", 1'b0, irq)
		ret();
		rd(`TLIA_ADDR_STATE, 8'h68);
		ret();
		quiet(10);
		$display("preemption done");
		// Line A edge, slow CPU, hardware clear
		@(posedge sys_clk_i);
		slow <= 1'b1;
		ext_a <= 1'b0;
		wait_call(16'h0003);
		rd(`TLIA_ADDR_PND0, 8'h10);
		@(posedge sys_clk_i);
		ext_a <= 1'b1;
		ret();
		// Read-only warning flag gated by its enable
		@(posedge sys_clk_i);
		warn_n <= 1'b0;
		quiet(15);
		wr(`TLIA_ADDR_PND2, 8'h00);
		rd(`TLIA_ADDR_PND2, 8'h01);
		wr(`TLIA_ADDR_EN2, 8'h01);
		wait_call(16'h007B);
		$display("pins done");
		give_verdict();
	end
endmodule // tb_two_level_irq_arbiter
`default_nettype wire
